// file: pkg/bcvd_defines.vh
// Constants for the boot configuration vector decoder: register map, field
// positions, codes and timing counts.
// Assumes inclusion by bare name from the design files under core/.
`ifndef BCVD_DEFINES_VH
`define BCVD_DEFINES_VH

// Register byte offsets on the Avalon-MM slave.
`define BCVD_OFS_CAPTURE 4'h0
`define BCVD_OFS_PCI_CTRL 4'h4
`define BCVD_OFS_WDOG_CTRL 4'h8
`define BCVD_OFS_STATUS 4'hc

// Field positions inside the boot vector.
`define BCVD_F_MULT_HI 3
`define BCVD_F_MULT_LO 0
`define BCVD_F_EDIV_HI 5
`define BCVD_F_EDIV_LO 4
`define BCVD_F_ENDIAN 6
`define BCVD_F_RSTMODE 7
`define BCVD_F_PCI_HI 10
`define BCVD_F_PCI_LO 8
`define BCVD_F_WDOG_DIS 11
`define BCVD_F_RSV_LO_HI 13
`define BCVD_F_RSV_LO_LO 12
`define BCVD_F_RSV_HI_HI 15
`define BCVD_F_RSV_HI_LO 14

// Clock multiplier codes and the factors they select.
`define BCVD_MULT_BYPASS 4'h0
`define BCVD_MULT_X3 4'h1
`define BCVD_MULT_X4 4'h2
`define BCVD_MULT_X8 4'h6
`define BCVD_MULT_X10A 4'h7
`define BCVD_MULT_X10B 4'h8
`define BCVD_FACTOR_NONE 4'h0
`define BCVD_FACTOR_3 4'h3
`define BCVD_FACTOR_4 4'h4
`define BCVD_FACTOR_8 4'h8
`define BCVD_FACTOR_10 4'ha

// External clock divider codes, and the toggle interval in master cycles.
`define BCVD_EDIV_1 2'h0
`define BCVD_EDIV_2 2'h1
`define BCVD_EDIV_4 2'h2
`define BCVD_TOGGLE_1 3'h1
`define BCVD_TOGGLE_2 3'h2
`define BCVD_TOGGLE_4 3'h4

// Internal bus clock runs at one half of the pipeline clock.
`define BCVD_INTERNAL_BUS_CLOCK_RATIO 3'h2

// PCI mode codes.
`define BCVD_PCI_SAT_NRDY 3'h1
`define BCVD_PCI_SAT_SUSP 3'h2
`define BCVD_PCI_HOST_RR 3'h5

// Warm reset drive length in master clock cycles.
`define BCVD_WARM_CYCLES 13'd4000

// Sequencer states.
`define BCVD_ST_COLD 2'h0
`define BCVD_ST_PLL 2'h1
`define BCVD_ST_WARM 2'h2
`define BCVD_ST_RUN 2'h3

// Reset value of the filtered pins: {warm line, cold reset, select, vector}.
`define BCVD_SYNC_RST 19'h40000

`endif

// file: core/bcvd_tick_div.v
// Programmable tick divider: one-cycle enable pulse every div master cycles.
// Assumes div is held stable while run is high and is never zero.
`timescale 1ns/1ps
`default_nettype none

module bcvd_tick_div #(
    parameter W = 3
) (
    input wire mclk,
    input wire reset_n,
    input wire run,
    input wire [W-1:0] div,
    output reg tick
);

    reg [W-1:0] cnt_q;

    // Count 0 .. div-1; the pulse marks the last count so div 1 ticks every cycle.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= {W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            cnt_q <= {W{1'b0}};
            tick <= 1'b0;
        end else if (cnt_q >= div - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_q <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end

endmodule // bcvd_tick_div

`default_nettype wire

// file: core/bcvd_boot_decode.v
// Boot configuration vector capture, decode and reset sequencing.
// Assumes board straps drive the vector pins during cold reset and an
// Avalon-MM master reaches the registers on mclk.
//
// Contract
// - Latch vector at cold reset; readable capture register.
// - Bits 3:0 select pipeline clock multiplier.
// - Internal bus clock is half pipeline clock.
// - Bits 5:4 divide external bus clock output.
// - Bit 6 selects little or big endian.
// - Normal reset drives warm reset 4000 cycles.
// - Internal vector waits out 18-bit counter.
// - Bits 10:8 select the PCI mode.
// - PCI enable resets to one in satellite modes.
// - Bit 11 set leaves watchdog disabled.
// - Select pin chooses external or internal vector.
// - Cold reset initializes, loads vector, locks PLL.
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "bcvd_defines.vh"

module bcvd_boot_decode #(
    parameter [15:0] INT_VECTOR = 16'h0000,
    parameter PLL_CNT_W = 18
) (
    input wire mclk,
    input wire reset_n,
    input wire cold_reset_input_n,
    input wire external_vector_select,
    input wire [15:0] memory_address_pins,
    input wire warm_reset_line_in,
    output reg warm_reset_line_out,
    output reg warm_reset_line_oe,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg [3:0] pll_multiplier,
    output reg pll_bypass,
    output reg pll_locked,
    output reg config_valid,
    output wire internal_bus_clock_en,
    output reg external_bus_clock_out,
    output reg big_endian,
    output reg [2:0] pci_mode,
    output reg pci_enable,
    output reg watchdog_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    localparam SW = 19;
    localparam [SW-1:0] SYNC_RST = `BCVD_SYNC_RST;

    wire [SW-1:0] sync_in;
    reg [SW-1:0] s1_q;
    reg [SW-1:0] s2_q;
    reg [SW-1:0] s3_q;
    reg [SW-1:0] filt_q;

    assign sync_in = {warm_reset_line_in, cold_reset_input_n, external_vector_select,
                      memory_address_pins};

    // Three synchroniser flops and a filter flop per pin; a change counts only once stages two and three agree.
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi = gi + 1) begin : g_sync
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    s1_q[gi] <= SYNC_RST[gi];
                    s2_q[gi] <= SYNC_RST[gi];
                    s3_q[gi] <= SYNC_RST[gi];
                    filt_q[gi] <= SYNC_RST[gi];
                end else begin
                    s1_q[gi] <= sync_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    wire [15:0] pins_f = filt_q[15:0];
    wire ext_sel_f = filt_q[16];
    wire cold_n_f = filt_q[17];
    wire warm_in_f = filt_q[18];

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Multiplier factor; bypass and reserved codes give no factor.
    function [3:0] mult_factor;
        input [3:0] code;
        begin
            case (code)
                `BCVD_MULT_X3: mult_factor = `BCVD_FACTOR_3;
                `BCVD_MULT_X4: mult_factor = `BCVD_FACTOR_4;
                `BCVD_MULT_X8: mult_factor = `BCVD_FACTOR_8;
                `BCVD_MULT_X10A: mult_factor = `BCVD_FACTOR_10;
                `BCVD_MULT_X10B: mult_factor = `BCVD_FACTOR_10;
                default: mult_factor = `BCVD_FACTOR_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer.

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [15:0] vec_q;
    reg int_vec_q;
    reg [PLL_CNT_W-1:0] pll_cnt_q;
    reg [12:0] warm_cnt_q;
    wire [15:0] vec_src = ext_sel_f ? pins_f : INT_VECTOR;
    wire pll_done = &pll_cnt_q;
    wire warm_done = (warm_cnt_q == `BCVD_WARM_CYCLES);

    // Next state; a cold reset at any time restarts the whole sequence.
    always @* begin
        state_d = state_q;
        case (state_q)
            `BCVD_ST_COLD: begin
                if (cold_n_f) begin
                    state_d = ext_sel_f ? `BCVD_ST_WARM : `BCVD_ST_PLL;
                end
            end
            `BCVD_ST_PLL: begin
                if (pll_done) begin
                    state_d = `BCVD_ST_WARM;
                end
            end
            `BCVD_ST_WARM: begin
                if (warm_done) begin
                    state_d = `BCVD_ST_RUN;
                end
            end
            `BCVD_ST_RUN: state_d = `BCVD_ST_RUN;
            default: state_d = `BCVD_ST_COLD;
        endcase
        if (!cold_n_f) begin
            state_d = `BCVD_ST_COLD;
        end
    end

    // State, counters and the single capture taken as cold reset releases.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= `BCVD_ST_COLD;
            vec_q <= 16'h0000;
            int_vec_q <= 1'b0;
            pll_cnt_q <= {PLL_CNT_W{1'b0}};
            warm_cnt_q <= 13'd0;
        end else begin
            state_q <= state_d;
            if (state_q == `BCVD_ST_COLD && cold_n_f) begin
                vec_q <= vec_src;
                int_vec_q <= ~ext_sel_f;
            end
            // The stabilization counter free-runs to all ones, then stops.
            if (state_q == `BCVD_ST_PLL && !pll_done) begin
                pll_cnt_q <= pll_cnt_q + {{(PLL_CNT_W-1){1'b0}}, 1'b1};
            end else if (state_q == `BCVD_ST_COLD) begin
                pll_cnt_q <= {PLL_CNT_W{1'b0}};
            end
            if (state_q == `BCVD_ST_WARM && !warm_done) begin
                warm_cnt_q <= warm_cnt_q + 13'd1;
            end else if (state_q != `BCVD_ST_WARM) begin
                warm_cnt_q <= 13'd0;
            end
        end
    end

    // Warm reset is open drain: pulled low through cold, PLL and warm phases.
    // The reserved reset mode is treated as normal so the line is never skipped.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            warm_reset_line_out <= 1'b0;
            warm_reset_line_oe <= 1'b1;
        end else begin
            warm_reset_line_out <= 1'b0;
            warm_reset_line_oe <= (state_d != `BCVD_ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded settings, loaded at the capture; PCI enable and watchdog enable also take register writes.

    reg pci_en_wr;
    reg pci_en_wval;
    reg wdog_wr;
    reg wdog_wval;
    wire commit = (state_q == `BCVD_ST_COLD) && cold_n_f;
    wire [2:0] pci_src = vec_src[`BCVD_F_PCI_HI:`BCVD_F_PCI_LO];

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pll_multiplier <= `BCVD_FACTOR_NONE;
            pll_bypass <= 1'b0;
            pll_locked <= 1'b0;
            config_valid <= 1'b0;
            big_endian <= 1'b0;
            pci_mode <= 3'h0;
            pci_enable <= 1'b0;
            watchdog_enable <= 1'b0;
        end else begin
            pll_locked <= (state_d == `BCVD_ST_WARM) || (state_d == `BCVD_ST_RUN);
            config_valid <= (state_d != `BCVD_ST_COLD);
            if (commit) begin
                pll_multiplier <= mult_factor(vec_src[`BCVD_F_MULT_HI:`BCVD_F_MULT_LO]);
                pll_bypass <= (vec_src[`BCVD_F_MULT_HI:`BCVD_F_MULT_LO] == `BCVD_MULT_BYPASS);
                big_endian <= vec_src[`BCVD_F_ENDIAN];
                pci_mode <= pci_src;
                pci_enable <= (pci_src == `BCVD_PCI_SAT_NRDY) ||
                              (pci_src == `BCVD_PCI_SAT_SUSP);
                watchdog_enable <= ~vec_src[`BCVD_F_WDOG_DIS];
            end else begin
                if (pci_en_wr) begin
                    pci_enable <= pci_en_wval;
                end
                if (wdog_wr) begin
                    watchdog_enable <= wdog_wval;
                end
            end
        end
    end

    // Flags for straps the board should never present; they only report.
    wire [3:0] mult_code = vec_q[`BCVD_F_MULT_HI:`BCVD_F_MULT_LO];
    wire fault_mult = config_valid && !int_vec_q && !pll_bypass &&
                      (mult_factor(mult_code) == `BCVD_FACTOR_NONE);
    wire fault_rsv_lo = |vec_q[`BCVD_F_RSV_LO_HI:`BCVD_F_RSV_LO_LO];
    wire fault_rsv_hi = |vec_q[`BCVD_F_RSV_HI_HI:`BCVD_F_RSV_HI_LO];
    wire fault_field = (vec_q[`BCVD_F_PCI_HI:`BCVD_F_PCI_LO] > `BCVD_PCI_HOST_RR) ||
                       (&vec_q[`BCVD_F_EDIV_HI:`BCVD_F_EDIV_LO]);

    ////////////////////////////////////////////////////////////////////////////
    // Clock enables.

    reg [2:0] toggle_div;
    wire ext_tick;

    // Reserved divider code 0x3 falls back to the slowest setting.
    always @* begin
        case (vec_q[`BCVD_F_EDIV_HI:`BCVD_F_EDIV_LO])
            `BCVD_EDIV_1: toggle_div = `BCVD_TOGGLE_1;
            `BCVD_EDIV_2: toggle_div = `BCVD_TOGGLE_2;
            `BCVD_EDIV_4: toggle_div = `BCVD_TOGGLE_4;
            default: toggle_div = `BCVD_TOGGLE_4;
        endcase
    end

    // Internal bus tick at half rate, fixed whatever the multiplier.
    bcvd_tick_div #(.W(3)) u_internal_bus_clock_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(pll_locked),
        .div(`BCVD_INTERNAL_BUS_CLOCK_RATIO),
        .tick(internal_bus_clock_en)
    );

    // External clock toggles every N cycles, so its period is N internal periods.
    bcvd_tick_div #(.W(3)) u_ext_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(pll_locked),
        .div(toggle_div),
        .tick(ext_tick)
    );

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            external_bus_clock_out <= 1'b0;
        end else if (!pll_locked) begin
            external_bus_clock_out <= 1'b0;
        end else if (ext_tick) begin
            external_bus_clock_out <= ~external_bus_clock_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then the answer.

    reg ack_q;
    wire req = avs_read | avs_write;
    wire take = req & ack_q;

    assign avs_waitrequest = req & ~ack_q;

    // The wait cycle gives read data a full cycle to settle from the decode.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Writes land on the edge where waitrequest is low; unmapped writes drop.
    always @* begin
        pci_en_wr = take && avs_write && avs_byteenable[0] &&
                    (avs_address == `BCVD_OFS_PCI_CTRL);
        pci_en_wval = avs_writedata[0];
        wdog_wr = take && avs_write && avs_byteenable[0] &&
                  (avs_address == `BCVD_OFS_WDOG_CTRL);
        wdog_wval = avs_writedata[0];
    end

    // Read data is loaded in the wait cycle; unmapped offsets read zero.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                `BCVD_OFS_CAPTURE: avs_readdata <= {16'h0000, vec_q};
                `BCVD_OFS_PCI_CTRL: avs_readdata <= {31'h00000000, pci_enable};
                `BCVD_OFS_WDOG_CTRL: avs_readdata <= {31'h00000000, watchdog_enable};
                `BCVD_OFS_STATUS: avs_readdata <= {20'h00000, fault_field, fault_rsv_hi,
                                                   fault_rsv_lo, fault_mult, warm_in_f,
                                                   int_vec_q, pll_locked, config_valid,
                                                   2'h0, state_q};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

endmodule // bcvd_boot_decode

`default_nettype wire

// file: tb/bcvd_board_model.sv
// Board model: straps the boot vector and pulls the warm reset wire up.
// Assumes the bench sets the wanted vector, select and cold reset level.
`timescale 1ns/1ps
`default_nettype none

module bcvd_board_model (
    input wire logic mclk,
    input wire logic cold_req_n,
    input wire logic sel_req,
    input wire logic [15:0] vec_req,
    input wire logic oe,
    input wire logic out,
    output wire logic cold_reset_input_n,
    output wire logic external_vector_select,
    output wire logic [15:0] memory_address_pins,
    output wire logic warm_reset_line_in
);
    logic [3:0] hold_q = 4'hc;
    logic [15:0] junk_q = 16'ha5c3;

    // Straps hold only briefly after cold release, then the bus carries traffic.
    always_ff @(posedge mclk) begin
        hold_q <= !cold_req_n ? 4'hc : hold_q - {3'h0, hold_q != 4'h0};
        junk_q <= ~junk_q + 16'h1357;
    end

    ////////////////////////////////////////////////////////////
    // Pin levels seen by the device.
    assign cold_reset_input_n = cold_req_n;
    assign external_vector_select = sel_req;
    assign memory_address_pins = hold_q != 4'h0 ? {4'h0, vec_req[11:0]} : junk_q;
    // The wire has a pull-up, so it is high unless the device drives it.
    assign warm_reset_line_in = oe ? out : 1'b1;
endmodule // bcvd_board_model

`default_nettype wire

// file: tb/bcvd_checker.sv
// Checker: concurrent properties on the boot decoder's ports.
// Assumes it is bound to bcvd_boot_decode, with one clock, mclk.
`timescale 1ns/1ps
`default_nettype none

module bcvd_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic warm_reset_line_out,
    input wire logic warm_reset_line_oe,
    input wire logic config_valid,
    input wire logic pll_locked,
    input wire logic pll_bypass,
    input wire logic [3:0] pll_multiplier,
    input wire logic internal_bus_clock_en,
    input wire logic big_endian,
    input wire logic [2:0] pci_mode,
    input wire logic pci_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [12:0] warm_q;

    // Warm drive length; it saturates so a full-length PLL count cannot wrap it.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            warm_q <= 13'h0;
        end else if (!(config_valid && warm_reset_line_oe)) begin
            warm_q <= 13'h0;
        end else if (warm_q != 13'h1fff) begin
            warm_q <= warm_q + 13'h1;
        end
    end

    ////////////////////////////////////////////////////////////
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_tick_pair;
        internal_bus_clock_en ##1 pll_locked [*2];
    endsequence

    bus_wait_a: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
        else $error("bus answer not after one wait cycle");
    tick_gap_a: assert property (internal_bus_clock_en |=> !internal_bus_clock_en)
        else $error("bus tick on two cycles in a row");
    tick_rate_a: assert property (s_tick_pair |-> internal_bus_clock_en)
        else $error("bus tick missing after two cycles");
    open_drain_a: assert property (!warm_reset_line_out)
        else $error("warm line driven high");
    cold_drive_a: assert property (!config_valid |-> warm_reset_line_oe)
        else $error("warm line released in cold reset");
    lock_valid_a: assert property (pll_locked |-> config_valid)
        else $error("lock without captured vector");
    mult_legal_a: assert property (pll_bypass |-> pll_multiplier == 4'h0)
        else $error("bypass with nonzero factor");
    hold_cfg_a: assert property (config_valid && $past(config_valid) |->
        $stable(pll_multiplier) && $stable(big_endian) && $stable(pci_mode))
        else $error("decoded setting changed after capture");
    pci_en_a: assert property ($rose(config_valid) |->
        pci_enable == (pci_mode == 3'h1 || pci_mode == 3'h2))
        else $error("pci enable wrong at capture");
    warm_len_a: assert property ($fell(warm_reset_line_oe) && config_valid |->
        warm_q >= 13'd4000)
        else $error("warm line released too early");
endmodule // bcvd_checker

bind bcvd_boot_decode bcvd_checker bcvd_checker_inst (.mclk(mclk), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .warm_reset_line_out(warm_reset_line_out), .warm_reset_line_oe(warm_reset_line_oe),
    .config_valid(config_valid), .pll_locked(pll_locked), .pll_bypass(pll_bypass),
    .pll_multiplier(pll_multiplier), .internal_bus_clock_en(internal_bus_clock_en),
    .big_endian(big_endian), .pci_mode(pci_mode), .pci_enable(pci_enable));

`default_nettype wire

// file: tb/testbench.sv
// Testbench: boots the decoder with a table of vectors, then odd cases.
// Assumes the board model and the checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cold_req_n = 1'b0;
    logic sel_req = 1'b1;
    logic [15:0] vec_req = 16'h0000;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    wire [31:0] rdata;
    wire wreq, locked, valid, ext_clk, oe, wout, cold_n, sel, warm_in;
    wire [15:0] pins;
    wire [3:0] mult;
    wire [2:0] pmode;
    wire bypass, tick, big_e, pen, wden;
    int err_count = 0;
    int compares = 0;
    logic [27:0] rows [0:6] = '{28'h0000010, 28'h0951321, 28'h0222441,
        28'h0b46810, 28'h0417a20, 28'h0d68a40, 28'h0035040}; // Vector, factor, half, pci en.

    // Shortened PLL count keeps the internal path quick.
    bcvd_boot_decode #(.INT_VECTOR(16'h0146), .PLL_CNT_W(4)) bcvd_boot_decode_inst (
        .mclk(mclk), .reset_n(reset_n), .cold_reset_input_n(cold_n),
        .external_vector_select(sel), .memory_address_pins(pins),
        .warm_reset_line_in(warm_in), .warm_reset_line_out(wout), .warm_reset_line_oe(oe),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .pll_multiplier(mult),
        .pll_bypass(bypass), .pll_locked(locked), .config_valid(valid),
        .internal_bus_clock_en(tick), .external_bus_clock_out(ext_clk),
        .big_endian(big_e), .pci_mode(pmode), .pci_enable(pen), .watchdog_enable(wden));
    bcvd_board_model bcvd_board_model_inst (.mclk(mclk), .cold_req_n(cold_req_n),
        .sel_req(sel_req), .vec_req(vec_req), .oe(oe), .out(wout),
        .cold_reset_input_n(cold_n), .external_vector_select(sel),
        .memory_address_pins(pins), .warm_reset_line_in(warm_in));

    initial begin
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////
    // One bus transfer; waitrequest is sampled at each rising edge, and read data is
    // taken at the edge where it is seen low, before anything is released.
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        int n;
        begin
            @(posedge mclk);
            avs_address <= a;
            avs_write <= w;
            avs_read <= !w;
            avs_writedata <= d;
            avs_byteenable <= be;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (wreq !== 1'b0 && n < 50);
            if (wreq !== 1'b0) begin
                err_count++;
            end
            q = rdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    // Cold reset with the given straps; returns once a vector is captured.
    task cold_boot(input logic s, input logic [15:0] v);
        int n;
        begin
            cold_req_n <= 1'b0;
            sel_req <= s;
            vec_req <= v;
            repeat (8) @(posedge mclk);
            cold_req_n <= 1'b1;
            n = 0;
            while (valid !== 1'b1 && n < 40) begin
                @(posedge mclk);
                n++;
            end
            if (valid !== 1'b1) begin
                err_count++;
            end
        end
    endtask

    // Half period of the external clock in master cycles.
    task half(output logic [3:0] h);
        logic e;
        begin
            e = ext_clk;
            h = 4'h0;
            while (ext_clk === e && h < 4'hf) begin
                @(posedge mclk);
                h++;
            end
            e = ext_clk;
            h = 4'h0;
            while (ext_clk === e && h < 4'hf) begin
                @(posedge mclk);
                h++;
            end
        end
    endtask

    task report_and_stop;
        begin
            if (err_count == 0 && compares > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence: table of vectors, then warm timing, registers, internal path, reset.
    initial begin
        logic [27:0] r;
        logic [31:0] q;
        logic [3:0] h;
        int n;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            r = rows[i];
            cold_boot(1'b1, r[27:12]);
            repeat (2) @(posedge mclk);
            `CHK(mult, r[11:8])
            `CHK(bypass, r[15:12] == 4'h0)
            `CHK(big_e, r[18])
            `CHK(pmode, r[22:20])
            `CHK(pen, r[0])
            `CHK(wden, ~r[23])
            bus(1'b0, 4'h0, 32'h0, 4'h1, q);
            `CHK(q, {16'h0, r[27:12]})
            half(h);
            `CHK(h, r[7:4])
        end
        cold_boot(1'b1, 16'h0000);
        n = 0;
        while (oe !== 1'b0 && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        `CHK(n > 3998 && n < 4003, 1'b1)
        bus(1'b1, 4'h4, 32'h1, 4'h0, q);
        bus(1'b0, 4'h4, 32'h0, 4'h1, q);
        `CHK(q, 32'h0)
        bus(1'b1, 4'h4, 32'h1, 4'h1, q);
        bus(1'b0, 4'h4, 32'h0, 4'h1, q);
        `CHK(q, 32'h1)
        `CHK(pen, 1'b1)
        bus(1'b1, 4'h8, 32'h0, 4'h1, q);
        @(posedge mclk);
        `CHK(wden, 1'b0)
        bus(1'b1, 4'h0, 32'hffff, 4'hf, q);
        bus(1'b0, 4'h0, 32'h0, 4'h1, q);
        `CHK(q, 32'h0)
        bus(1'b0, 4'h2, 32'h0, 4'h1, q);
        `CHK(q, 32'h0)
        bus(1'b0, 4'hc, 32'h0, 4'h1, q);
        `CHK(q, 32'h000000b3)
        cold_boot(1'b0, 16'h0fff);
        n = 0;
        while (locked !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        `CHK(n > 12 && n < 17, 1'b1)
        bus(1'b0, 4'h0, 32'h0, 4'h1, q);
        `CHK(q, 32'h0146)
        `CHK(mult, 4'h8)
        `CHK(pen, 1'b1)
        `CHK(wden, 1'b1)
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(oe, 1'b1)
        `CHK(valid, 1'b0)
        report_and_stop;
    end

    // A hang counts as a mismatch; the run needs about 4300 cycles.
    initial begin
        #100000;
        err_count++;
        report_and_stop;
    end
endmodule // testbench

`default_nettype wire
